/* File: cfa_addr_gen.sv */
// operand address former for one operand
`timescale 1ns/1ps
`default_nettype none
module cfa_addr_gen (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request and registered answer
  cfa_addr_if.former port
);
  logic [15:0] ea_d;
  logic mem_d;

  always_comb begin
    ea_d = 16'h0000;
    mem_d = 1'b0;
    unique case (port.mode)
      cfa_pkg::register_only_mode: begin
        // operands sit in core registers, no bus cycle
        ea_d = 16'h0000; // [RULE15]
        mem_d = 1'b0; // [RULE15]
      end
      cfa_pkg::pc_offset_mode: begin
        ea_d = port.pc + {{8{port.byte_lo[7]}}, port.byte_lo}; // [RULE16]
        mem_d = 1'b0;
      end
      cfa_pkg::inline_operand_mode: begin
        // operand bytes follow the opcode, pc points at them
        ea_d = port.pc; // [RULE17]
        mem_d = 1'b1;
      end
      cfa_pkg::direct_page_mode: begin
        ea_d = {cfa_pkg::DIRECT_PAGE_HI, port.byte_lo}; // [RULE18]
        mem_d = 1'b1;
      end
      cfa_pkg::full_address_mode: begin
        ea_d = {port.byte_hi, port.byte_lo}; // [RULE19] [RULE12]
        mem_d = 1'b1;
      end
      default: begin
        ea_d = 16'h0000;
        mem_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port.ea <= 16'h0000;
      port.mem_access <= 1'b0;
      port.inline_value <= 16'h0000;
    end else if (port.req) begin
      port.ea <= ea_d;
      port.mem_access <= mem_d;
      port.inline_value <= {port.byte_hi, port.byte_lo}; // [RULE17]
    end
  end
endmodule
`default_nettype wire

/* File: cfa_addr_if.sv */
// request and answer of one operand address former
`timescale 1ns/1ps
`default_nettype none
interface cfa_addr_if;
  logic req;
  cfa_pkg::cfa_mode_type mode;
  logic [7:0] byte_hi;
  logic [7:0] byte_lo;
  logic [15:0] pc;
  logic [15:0] ea;
  logic mem_access;
  logic [15:0] inline_value;
  modport requester(output req, mode, byte_hi, byte_lo, pc,
    input ea, mem_access, inline_value);
  modport former(input req, mode, byte_hi, byte_lo, pc,
    output ea, mem_access, inline_value);
endinterface
`default_nettype wire

/* File: cfa_core.sv */
// flag register, branch decision, interrupt entry and operand addressing
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - flag register is eight bits; bits 6 and 5 always read one
// RULE2 - bit 7 set on two's complement overflow, cleared otherwise
// RULE3 - signed branches use the overflow flag in their condition
// RULE4 - bit 4 set on carry from bit 3 into bit 4 on adds
// RULE5 - decimal adjust uses half-carry and carry to correct the prior sum
// RULE6 - mask bit 3 set blocks maskable interrupts, clear accepts them
// RULE7 - mask set after the stacking, before the handler's first instruction
// RULE8 - no interrupt at the boundary right after the mask is cleared
// RULE9 - bit 2 copies the msb of results and loaded or stored values
// RULE10 - bit 1 set when the result or moved value is all zero
// RULE11 - bit 0 is carry or borrow; shifts, rotates, bit tests update it
// RULE12 - everything is reached through one 16-bit address space
// RULE13 - test-and-branch uses its mode for the operand, relative for target
// RULE14 - moves form source and destination addresses independently
// RULE15 - register-only mode makes no memory access for operands
// RULE16 - relative branch sign-extends the 8-bit offset and adds it to pc
// RULE17 - inline operand follows the opcode, high byte first
// RULE18 - direct page address is 0x00 prefixed to the address byte
// RULE19 - full address mode takes two bytes after the opcode, high first
// RULE20 - interrupt pushes pc low, pc high, index low, accumulator, flags
// RULE21 - wait clears the mask then halts until interrupt or reset
// RULE22 - writing flags from the accumulator keeps the fixed bits at one
// RULE23 - flags an operation does not define keep their old values
module cfa_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // operation request
  input wire logic op_valid,
  input wire cfa_pkg::cfa_op_type op_sel,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic [15:0] op_wide,
  input wire logic [2:0] op_bit,
  // operation answer
  output logic [7:0] result_q,
  output logic [7:0] condition_flags,
  // branch decision
  input wire logic br_valid,
  input wire cfa_pkg::cfa_cond_type br_cond,
  input wire logic [7:0] br_offset,
  input wire logic [15:0] pc,
  output logic br_taken_q,
  output logic [15:0] br_target_q,
  // operand addressing
  input wire logic addr_req,
  input wire cfa_pkg::cfa_mode_type src_mode,
  input wire logic [7:0] src_hi,
  input wire logic [7:0] src_lo,
  input wire cfa_pkg::cfa_mode_type dst_mode,
  input wire logic [7:0] dst_hi,
  input wire logic [7:0] dst_lo,
  output logic [15:0] src_ea,
  output logic src_mem,
  output logic [15:0] inline_value,
  output logic [15:0] dst_ea,
  output logic dst_mem,
  // interrupt entry
  input wire logic irq_req,
  input wire logic insn_boundary,
  input wire logic [7:0] index_lo,
  input wire logic [7:0] acc,
  output logic irq_busy,
  output logic push_valid_q,
  output logic [7:0] push_data_q,
  output logic irq_enter_q,
  output logic halted
);
  typedef enum logic [1:0] {
    irq_idle, irq_push, irq_mask, irq_waiting
  } cfa_irq_state_type;

  cfa_irq_state_type state_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] res_d;
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [4:0] nib_sum;
  logic cin;
  logic [7:0] bcd_fix;
  logic [8:0] bcd9;
  logic inhibit_q;
  logic accept;
  logic [2:0] push_idx_q;
  logic [15:0] saved_pc_q;
  logic [7:0] saved_x_q;
  logic [7:0] saved_a_q;
  logic [7:0] saved_flags_q;
  logic cond_ok;
  logic mask_clears;

  cfa_addr_if src_if ();
  cfa_addr_if dst_if ();

  // two formers so a move gets both addresses in the same cycle
  assign src_if.req = addr_req;
  assign src_if.mode = src_mode; // [RULE14] [RULE13]
  assign src_if.byte_hi = src_hi;
  assign src_if.byte_lo = src_lo;
  assign src_if.pc = pc;
  assign dst_if.req = addr_req;
  assign dst_if.mode = dst_mode; // [RULE14]
  assign dst_if.byte_hi = dst_hi;
  assign dst_if.byte_lo = dst_lo;
  assign dst_if.pc = pc;

  cfa_addr_gen u_src (
    .clk(clk),
    .reset(reset),
    .port(src_if.former)
  );

  cfa_addr_gen u_dst (
    .clk(clk),
    .reset(reset),
    .port(dst_if.former)
  );

  assign src_ea = src_if.ea;
  assign src_mem = src_if.mem_access;
  assign inline_value = src_if.inline_value;
  assign dst_ea = dst_if.ea;
  assign dst_mem = dst_if.mem_access;

  // fixed bits forced on the read path too, so no write can leak through
  assign condition_flags = flags_q | cfa_pkg::FIXED_ONES; // [RULE1]

  // arithmetic and flag computation
  always_comb begin
    cin = 1'b0;
    if ((op_sel == cfa_pkg::op_adc) || (op_sel == cfa_pkg::op_sbc)) begin
      cin = flags_q[cfa_pkg::FLAG_C];
    end
    sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
    diff9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
    nib_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
    bcd_fix = 8'h00;
    if (flags_q[cfa_pkg::FLAG_H] || (op_a[3:0] > cfa_pkg::BCD_NIB_MAX)) begin
      bcd_fix = bcd_fix | cfa_pkg::BCD_LOW_FIX; // [RULE5]
    end
    if (flags_q[cfa_pkg::FLAG_C] || (op_a > cfa_pkg::BCD_BYTE_MAX)) begin
      bcd_fix = bcd_fix | cfa_pkg::BCD_HIGH_FIX; // [RULE5]
    end
    bcd9 = {1'b0, op_a} + {1'b0, bcd_fix};
    flags_d = flags_q; // [RULE23]
    res_d = result_q;
    unique case (op_sel)
      cfa_pkg::op_add, cfa_pkg::op_adc: begin
        res_d = sum9[7:0];
        flags_d[cfa_pkg::FLAG_H] = nib_sum[4]; // [RULE4]
        flags_d[cfa_pkg::FLAG_C] = sum9[8]; // [RULE11]
        flags_d[cfa_pkg::FLAG_V] = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]); // [RULE2]
      end
      cfa_pkg::op_sub, cfa_pkg::op_sbc: begin
        res_d = diff9[7:0];
        flags_d[cfa_pkg::FLAG_C] = diff9[8]; // [RULE11]
        flags_d[cfa_pkg::FLAG_V] = (op_a[7] != op_b[7]) && (diff9[7] != op_a[7]); // [RULE2]
      end
      cfa_pkg::op_and: begin
        res_d = op_a & op_b;
        flags_d[cfa_pkg::FLAG_V] = 1'b0; // [RULE2]
      end
      cfa_pkg::op_or: begin
        res_d = op_a | op_b;
        flags_d[cfa_pkg::FLAG_V] = 1'b0; // [RULE2]
      end
      cfa_pkg::op_eor: begin
        res_d = op_a ^ op_b;
        flags_d[cfa_pkg::FLAG_V] = 1'b0; // [RULE2]
      end
      cfa_pkg::op_lsl: begin
        res_d = {op_a[6:0], 1'b0};
        flags_d[cfa_pkg::FLAG_C] = op_a[7]; // [RULE11]
      end
      cfa_pkg::op_lsr: begin
        res_d = {1'b0, op_a[7:1]};
        flags_d[cfa_pkg::FLAG_C] = op_a[0]; // [RULE11]
      end
      cfa_pkg::op_rol: begin
        res_d = {op_a[6:0], flags_q[cfa_pkg::FLAG_C]};
        flags_d[cfa_pkg::FLAG_C] = op_a[7]; // [RULE11]
      end
      cfa_pkg::op_ror: begin
        res_d = {flags_q[cfa_pkg::FLAG_C], op_a[7:1]};
        flags_d[cfa_pkg::FLAG_C] = op_a[0]; // [RULE11]
      end
      cfa_pkg::op_load8: begin
        res_d = op_a;
        flags_d[cfa_pkg::FLAG_V] = 1'b0; // [RULE2]
      end
      cfa_pkg::decimal_adjust_op: begin
        res_d = bcd9[7:0]; // [RULE5]
        flags_d[cfa_pkg::FLAG_C] = flags_q[cfa_pkg::FLAG_C] | bcd_fix[6]; // [RULE5]
      end
      cfa_pkg::op_bit_test: begin
        flags_d[cfa_pkg::FLAG_C] = op_a[op_bit]; // [RULE11] [RULE13]
      end
      cfa_pkg::clear_mask_op, cfa_pkg::op_wait: begin
        flags_d[cfa_pkg::FLAG_I] = 1'b0; // [RULE21]
      end
      cfa_pkg::op_set_mask: begin
        flags_d[cfa_pkg::FLAG_I] = 1'b1;
      end
      cfa_pkg::op_flags_from_acc: begin
        flags_d = op_a | cfa_pkg::FIXED_ONES; // [RULE22]
      end
      default: begin
        flags_d = flags_q;
      end
    endcase
    // shifts and rotates set overflow to the new msb xor the new carry
    unique case (op_sel)
      cfa_pkg::op_lsl, cfa_pkg::op_lsr, cfa_pkg::op_rol, cfa_pkg::op_ror: begin
        flags_d[cfa_pkg::FLAG_V] = res_d[7] ^ flags_d[cfa_pkg::FLAG_C]; // [RULE2]
      end
      default: begin
      end
    endcase
    unique case (op_sel)
      cfa_pkg::op_add, cfa_pkg::op_adc, cfa_pkg::op_sub, cfa_pkg::op_sbc,
      cfa_pkg::op_and, cfa_pkg::op_or, cfa_pkg::op_eor, cfa_pkg::op_lsl,
      cfa_pkg::op_lsr, cfa_pkg::op_rol, cfa_pkg::op_ror, cfa_pkg::op_load8,
      cfa_pkg::decimal_adjust_op: begin
        flags_d[cfa_pkg::FLAG_N] = res_d[7]; // [RULE9]
        flags_d[cfa_pkg::FLAG_Z] = (res_d == 8'h00); // [RULE10]
      end
      cfa_pkg::op_load16: begin
        flags_d[cfa_pkg::FLAG_N] = op_wide[15]; // [RULE9]
        flags_d[cfa_pkg::FLAG_Z] = (op_wide == 16'h0000); // [RULE10]
        flags_d[cfa_pkg::FLAG_V] = 1'b0; // [RULE2]
      end
      default: begin
        flags_d[cfa_pkg::FLAG_N] = flags_d[cfa_pkg::FLAG_N];
      end
    endcase
    flags_d = flags_d | cfa_pkg::FIXED_ONES; // [RULE1]
  end

  // an executed clear_mask_op or op_flags_from_acc that takes the mask from one to zero
  assign mask_clears = op_valid && flags_q[cfa_pkg::FLAG_I] && !flags_d[cfa_pkg::FLAG_I]
    && ((op_sel == cfa_pkg::clear_mask_op) || (op_sel == cfa_pkg::op_flags_from_acc));

  // maskable request only when the mask is clear and no shadow is pending
  assign accept = (state_q == irq_idle) && insn_boundary && irq_req
    && !flags_q[cfa_pkg::FLAG_I] && !inhibit_q; // [RULE6] [RULE8]

  // flag register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_q <= cfa_pkg::FLAGS_RESET;
    end else if (state_q == irq_mask) begin
      flags_q[cfa_pkg::FLAG_I] <= 1'b1; // [RULE7]
    end else if (op_valid && (state_q == irq_idle)) begin
      flags_q <= flags_d;
    end
  end

  // result register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_q <= 8'h00;
    end else if (op_valid && (state_q == irq_idle)) begin
      result_q <= res_d;
    end
  end

  // one-instruction shadow after the mask is cleared
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inhibit_q <= 1'b0;
    end else if (mask_clears && (state_q == irq_idle)) begin
      inhibit_q <= 1'b1; // [RULE8]
    end else if (insn_boundary) begin
      inhibit_q <= 1'b0; // [RULE8]
    end
  end

  // branch condition
  always_comb begin
    cond_ok = 1'b0;
    unique case (br_cond)
      cfa_pkg::br_always: cond_ok = 1'b1;
      cfa_pkg::br_equal: cond_ok = flags_q[cfa_pkg::FLAG_Z];
      cfa_pkg::br_not_equal: cond_ok = !flags_q[cfa_pkg::FLAG_Z];
      cfa_pkg::br_carry_set: cond_ok = flags_q[cfa_pkg::FLAG_C];
      cfa_pkg::br_carry_clear: cond_ok = !flags_q[cfa_pkg::FLAG_C];
      cfa_pkg::branch_greater_op: cond_ok = !(flags_q[cfa_pkg::FLAG_Z]
        | (flags_q[cfa_pkg::FLAG_N] ^ flags_q[cfa_pkg::FLAG_V])); // [RULE3]
      cfa_pkg::branch_greater_equal_op: cond_ok =
        !(flags_q[cfa_pkg::FLAG_N] ^ flags_q[cfa_pkg::FLAG_V]); // [RULE3]
      cfa_pkg::branch_less_equal_op: cond_ok = flags_q[cfa_pkg::FLAG_Z]
        | (flags_q[cfa_pkg::FLAG_N] ^ flags_q[cfa_pkg::FLAG_V]); // [RULE3]
      cfa_pkg::branch_less_op: cond_ok =
        flags_q[cfa_pkg::FLAG_N] ^ flags_q[cfa_pkg::FLAG_V]; // [RULE3]
      cfa_pkg::branch_bit_clear_op: cond_ok = !op_a[op_bit]; // [RULE13]
      cfa_pkg::branch_bit_set_op: cond_ok = op_a[op_bit]; // [RULE13]
      default: cond_ok = 1'b0;
    endcase
  end

  // branch target, relative to the pc after the offset byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      br_taken_q <= 1'b0;
      br_target_q <= 16'h0000;
    end else if (br_valid) begin
      br_taken_q <= cond_ok;
      if (cond_ok) begin
        br_target_q <= pc + {{8{br_offset[7]}}, br_offset}; // [RULE16] [RULE13]
      end else begin
        br_target_q <= pc;
      end
    end
  end

  // interrupt entry and wait sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= irq_idle;
      push_idx_q <= 3'h0;
    end else begin
      unique case (state_q)
        irq_idle: begin
          push_idx_q <= 3'h0;
          if (accept) begin
            state_q <= irq_push;
          end else if (op_valid && (op_sel == cfa_pkg::op_wait)) begin
            state_q <= irq_waiting; // [RULE21]
          end
        end
        irq_push: begin
          if (push_idx_q == cfa_pkg::PUSH_LAST) begin
            state_q <= irq_mask; // [RULE7]
          end else begin
            push_idx_q <= push_idx_q + 3'h1;
          end
        end
        irq_mask: begin
          state_q <= irq_idle;
        end
        irq_waiting: begin
          // mask was cleared on entry, so any request wakes
          if (irq_req) begin
            state_q <= irq_push; // [RULE21]
          end
        end
      endcase
    end
  end

  // snapshot of the stacked registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      saved_pc_q <= 16'h0000;
      saved_x_q <= 8'h00;
      saved_a_q <= 8'h00;
      saved_flags_q <= 8'h00;
    end else if (accept || ((state_q == irq_waiting) && irq_req)) begin
      saved_pc_q <= pc;
      saved_x_q <= index_lo;
      saved_a_q <= acc;
      saved_flags_q <= condition_flags;
    end
  end

  // stack byte stream
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      push_valid_q <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      push_valid_q <= (state_q == irq_push);
      unique case (push_idx_q)
        3'h0: push_data_q <= saved_pc_q[7:0]; // [RULE20]
        3'h1: push_data_q <= saved_pc_q[15:8]; // [RULE20]
        3'h2: push_data_q <= saved_x_q; // [RULE20]
        3'h3: push_data_q <= saved_a_q; // [RULE20]
        default: push_data_q <= saved_flags_q; // [RULE20]
      endcase
    end
  end

  // handler may start once the mask is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_enter_q <= 1'b0;
    end else begin
      irq_enter_q <= (state_q == irq_mask); // [RULE7]
    end
  end

  assign irq_busy = (state_q == irq_push) || (state_q == irq_mask);
  assign halted = (state_q == irq_waiting);
endmodule
`default_nettype wire

/* File: cfa_core_chk.sv */
// concurrent checks on the ports of the flag and address core
`timescale 1ns/1ps
`default_nettype none
module cfa_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // operations
  input wire logic op_valid,
  input wire cfa_pkg::cfa_op_type op_sel,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic [7:0] result_q,
  input wire logic [7:0] condition_flags,
  // branches
  input wire logic br_valid,
  input wire cfa_pkg::cfa_cond_type br_cond,
  input wire logic [7:0] br_offset,
  input wire logic [15:0] pc,
  input wire logic br_taken_q,
  input wire logic [15:0] br_target_q,
  // addressing
  input wire logic addr_req,
  input wire cfa_pkg::cfa_mode_type src_mode,
  input wire logic [7:0] src_hi,
  input wire logic [7:0] src_lo,
  input wire cfa_pkg::cfa_mode_type dst_mode,
  input wire logic [7:0] dst_hi,
  input wire logic [7:0] dst_lo,
  input wire logic [15:0] src_ea,
  input wire logic src_mem,
  input wire logic [15:0] inline_value,
  input wire logic [15:0] dst_ea,
  // interrupt entry
  input wire logic irq_req,
  input wire logic insn_boundary,
  input wire logic irq_busy,
  input wire logic push_valid_q,
  input wire logic irq_enter_q,
  input wire logic halted
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic go;
  logic [8:0] s9;
  logic [4:0] s5;
  logic [4:0] add_f;
  logic [15:0] tgt;
  assign go = op_valid && !irq_busy && !halted;
  assign s9 = {1'b0, op_a} + {1'b0, op_b};
  assign s5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  // expected V H N Z C of a plain add
  assign add_f = {(op_a[7] == op_b[7]) && (s9[7] != op_a[7]), s5[4], s9[7],
    s9[7:0] == 8'h00, s9[8]};
  assign tgt = pc + {{8{br_offset[7]}}, br_offset};
  sequence s_stack;
    push_valid_q [*5] ##1 (irq_enter_q && condition_flags[3]);
  endsequence
  property p_fixed;
    condition_flags[6:5] == 2'b11;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed flag bits not one");
  property p_add;
    go && op_sel == cfa_pkg::op_add |=> result_q == $past(s9[7:0]) &&
      {condition_flags[7], condition_flags[4], condition_flags[2:0]} == $past(add_f) &&
      condition_flags[3] == $past(condition_flags[3]);
  endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_acc;
    go && op_sel == cfa_pkg::op_flags_from_acc |=> condition_flags == ($past(op_a) | 8'h60);
  endproperty
  a_acc: assert property (p_acc) else $error("flag write wrong");
  property p_wait;
    go && op_sel == cfa_pkg::op_wait |=> !condition_flags[3] && halted;
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not unmask and halt");
  property p_less;
    br_valid && br_cond == cfa_pkg::branch_less_op |=>
      br_taken_q == ($past(condition_flags[2]) ^ $past(condition_flags[7]));
  endproperty
  a_less: assert property (p_less) else $error("signed branch wrong");
  property p_tgt;
    br_valid |=> br_target_q == (br_taken_q ? $past(tgt) : $past(pc));
  endproperty
  a_tgt: assert property (p_tgt) else $error("branch target wrong");
  property p_dir;
    addr_req && src_mode == cfa_pkg::direct_page_mode |=>
      src_ea == {8'h00, $past(src_lo)} && src_mem;
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_full;
    addr_req && dst_mode == cfa_pkg::full_address_mode |=>
      dst_ea == {$past(dst_hi), $past(dst_lo)};
  endproperty
  a_full: assert property (p_full) else $error("full address wrong");
  property p_imm;
    addr_req && src_mode == cfa_pkg::inline_operand_mode |=>
      inline_value == {$past(src_hi), $past(src_lo)};
  endproperty
  a_imm: assert property (p_imm) else $error("inline operand wrong");
  property p_inh;
    addr_req && src_mode == cfa_pkg::register_only_mode |=> !src_mem;
  endproperty
  a_inh: assert property (p_inh) else $error("register mode touched memory");
  property p_mask;
    insn_boundary && irq_req && condition_flags[3] && !irq_busy && !halted |=> !irq_busy;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt taken");
  property p_irq;
    $rose(irq_busy) |-> ##1 s_stack;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt entry sequence wrong");
endmodule
bind cfa_core cfa_core_chk u_chk (.*);
`default_nettype wire

/* File: cfa_pkg.sv */
// constants and types shared by the flag and address logic
package cfa_pkg;
  localparam int FLAG_W = 8;
  localparam int ADDR_W = 16;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_V = 7;
  localparam logic [7:0] FIXED_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_NIB_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [2:0] PUSH_LAST = 3'h4;

  typedef enum logic [2:0] {
    register_only_mode,
    pc_offset_mode,
    inline_operand_mode,
    direct_page_mode,
    full_address_mode
  } cfa_mode_type;

  typedef enum logic [4:0] {
    op_none, op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_eor,
    op_lsl, op_lsr, op_rol, op_ror, op_load8, op_load16,
    decimal_adjust_op, op_bit_test, clear_mask_op, op_set_mask,
    op_flags_from_acc, op_wait
  } cfa_op_type;

  typedef enum logic [3:0] {
    br_always, br_equal, br_not_equal, br_carry_set, br_carry_clear,
    branch_greater_op, branch_greater_equal_op, branch_less_equal_op,
    branch_less_op, branch_bit_clear_op, branch_bit_set_op
  } cfa_cond_type;
endpackage

/* File: cfa_stack_model.sv */
// stack memory model collecting the bytes pushed on interrupt entry
`timescale 1ns/1ps
`default_nettype none
module cfa_stack_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // push stream
  input wire logic push_valid_q,
  input wire logic [7:0] push_data_q,
  // collected bytes, oldest on top
  output logic [39:0] stack_q,
  output logic [3:0] count_q
);
  // ram keeps contents over reset, only the count restarts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= 4'h0;
    end else if (push_valid_q) begin
      count_q <= count_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (push_valid_q) begin
      stack_q <= {stack_q[31:0], push_data_q};
    end
  end
endmodule
`default_nettype wire

/* File: test_cpu_flags_and_operand_addressing.sv */
// self-checking bench for the flag and address core
`timescale 1ns/1ps
`default_nettype none
module test_cpu_flags_and_operand_addressing;
  logic clk, reset, op_valid, br_valid, addr_req, irq_req, insn_boundary;
  cfa_pkg::cfa_op_type op_sel;
  cfa_pkg::cfa_cond_type br_cond;
  cfa_pkg::cfa_mode_type src_mode, dst_mode;
  logic [7:0] op_a, op_b, br_offset, src_hi, src_lo, dst_hi, dst_lo, index_lo, acc;
  logic [7:0] result_q, condition_flags, push_data_q;
  logic [15:0] op_wide, pc, br_target_q, src_ea, inline_value, dst_ea;
  logic [2:0] op_bit;
  logic br_taken_q, src_mem, dst_mem, irq_busy, push_valid_q, irq_enter_q, halted;
  logic [39:0] stack_q;
  logic [3:0] count_q;
  int fail_count, checked;
  cfa_core DUT (.*);
  cfa_stack_model u_stack (.*);
  always #25 clk = ~clk;
  task automatic summarize();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input cfa_pkg::cfa_op_type s, input logic [7:0] a);
    @(negedge clk);
    op_valid = 1'b1;
    op_sel = s;
    op_a = a;
    @(negedge clk);
    op_valid = 1'b0;
  endtask
  task automatic add(input logic [7:0] a, input logic [7:0] b);
    op_b = b;
    op(cfa_pkg::op_add, a);
  endtask
  task automatic br(input cfa_pkg::cfa_cond_type c, input logic [7:0] off, input logic tk);
    @(negedge clk);
    br_valid = 1'b1;
    br_cond = c;
    br_offset = off;
    @(negedge clk);
    br_valid = 1'b0;
    chk(16'(br_taken_q), 16'(tk));
    chk(br_target_q, tk ? pc + {{8{off[7]}}, off} : pc);
  endtask
  task automatic bound(input logic busy);
    @(negedge clk);
    insn_boundary = 1'b1;
    @(negedge clk);
    insn_boundary = 1'b0;
    chk(16'(irq_busy), 16'(busy));
  endtask
  task automatic enter(input logic [7:0] fl, input logic [3:0] n);
    logic got;
    irq_req = 1'b0;
    got = 1'b0;
    repeat (20) begin
      @(negedge clk);
      if (irq_enter_q === 1'b1) got = 1'b1;
    end
    chk({15'h0, got}, 16'h1);
    chk(16'(condition_flags[3]), 16'h1);
    chk(stack_q[39:24], 16'h3412);
    chk(stack_q[23:8], 16'h569a);
    chk({stack_q[7:0], 4'h0, count_q}, {fl, 4'h0, n});
  endtask
  task automatic t_arith();
    add(8'h7f, 8'h01);
    chk({result_q, condition_flags}, 16'h80fc);
    add(8'h80, 8'h80);
    chk({result_q, condition_flags}, 16'h00eb);
    add(8'h01, 8'h01);
    chk({result_q, condition_flags}, 16'h0268);
    add(8'h19, 8'h28);
    chk({result_q, condition_flags}, 16'h4178);
    op(cfa_pkg::decimal_adjust_op, 8'h41);
    chk(16'(result_q), 16'h0047);
    add(8'h99, 8'h01);
    op(cfa_pkg::decimal_adjust_op, 8'h9a);
    chk(16'({result_q, condition_flags[0]}), 16'h0001);
    op(cfa_pkg::op_flags_from_acc, 8'h00);
    chk(16'(condition_flags), 16'h0060);
    op(cfa_pkg::op_flags_from_acc, 8'hff);
    chk(16'(condition_flags), 16'h00ff);
  endtask
  task automatic t_branch();
    op_bit = 3'h4;
    op(cfa_pkg::op_bit_test, 8'h10);
    chk(16'(condition_flags[0]), 16'h0001);
    br(cfa_pkg::branch_bit_set_op, 8'h04, 1'b1);
    br(cfa_pkg::branch_bit_clear_op, 8'h04, 1'b0);
    op(cfa_pkg::op_flags_from_acc, 8'h04);
    br(cfa_pkg::branch_less_op, 8'h10, 1'b1);
    br(cfa_pkg::branch_less_equal_op, 8'h10, 1'b1);
    br(cfa_pkg::branch_greater_op, 8'h10, 1'b0);
    br(cfa_pkg::branch_greater_equal_op, 8'h10, 1'b0);
    op(cfa_pkg::op_flags_from_acc, 8'h84);
    br(cfa_pkg::branch_less_op, 8'h10, 1'b0);
    br(cfa_pkg::branch_greater_op, 8'h10, 1'b1);
    op(cfa_pkg::op_flags_from_acc, 8'h86);
    br(cfa_pkg::branch_greater_op, 8'h10, 1'b0);
    br(cfa_pkg::branch_less_equal_op, 8'h10, 1'b1);
    br(cfa_pkg::br_always, 8'h80, 1'b1);
    br(cfa_pkg::br_always, 8'h7f, 1'b1);
  endtask
  task automatic t_addr();
    @(negedge clk);
    addr_req = 1'b1;
    src_mode = cfa_pkg::direct_page_mode;
    dst_mode = cfa_pkg::full_address_mode;
    @(negedge clk);
    chk(src_ea, 16'h00ab);
    chk(dst_ea, 16'h1234);
    chk(16'(src_mem), 16'h0001);
    src_mode = cfa_pkg::inline_operand_mode;
    dst_mode = cfa_pkg::direct_page_mode;
    @(negedge clk);
    chk(inline_value, 16'heeab);
    chk(dst_ea, 16'h0034);
    src_mode = cfa_pkg::register_only_mode;
    dst_mode = cfa_pkg::register_only_mode;
    @(negedge clk);
    addr_req = 1'b0;
    chk(16'({src_mem, dst_mem}), 16'h0000);
  endtask
  task automatic t_irq();
    op(cfa_pkg::op_flags_from_acc, 8'h08);
    irq_req = 1'b1;
    bound(1'b0);
    op(cfa_pkg::clear_mask_op, 8'h00);
    chk(16'(condition_flags), 16'h0060);
    bound(1'b0);
    bound(1'b1);
    enter(8'h60, 4'h5);
    op(cfa_pkg::op_wait, 8'h00);
    chk(16'({halted, condition_flags[3]}), 16'h0002);
    irq_req = 1'b1;
    @(negedge clk);
    enter(8'h60, 4'ha);
    chk(16'(halted), 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {op_valid, br_valid, addr_req, irq_req, insn_boundary} = 5'h00;
    op_sel = cfa_pkg::op_none;
    br_cond = cfa_pkg::br_always;
    src_mode = cfa_pkg::register_only_mode;
    dst_mode = cfa_pkg::register_only_mode;
    {op_a, op_b, br_offset, op_bit, op_wide} = 43'h0;
    {src_hi, src_lo, dst_hi, dst_lo} = 32'heeab1234;
    {pc, index_lo, acc} = 32'h0010569a;
    fail_count = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk(16'({condition_flags, 7'h0, halted}), 16'h6800);
    t_arith();
    t_branch();
    t_addr();
    pc = 16'h1234;
    t_irq();
    summarize();
  end
  // eighty times the expected run
  initial begin
    #500000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
